// File: inc/dial_pkg.sv
// Purpose: constants for the call-setup dial and handshake block
// Assumes: 25 MHz MCLK, interval counts in dial ticks
// Notes:   tick period is a fixed localparam, the same in simulation
package dial_pkg;
   localparam int          CLK_HZ            = 25_000_000;
   localparam int          TICK_US           = 125;
   localparam int          TICK_CYC          = (CLK_HZ / 1_000_000) * TICK_US;
   localparam logic [2:0]  MODE_STANDBY      = 3'h0;
   localparam logic [2:0]  MODE_DIAL         = 3'h3;
   localparam int          DIGIT_LSB         = 0;
   localparam int          DIGIT_W           = 4;
   localparam int          CFG_MANUAL_BIT    = 10;
   localparam int          TRN_FORCE16_BIT   = 3;
   localparam int          TRN_USB1_BIT      = 5;
   localparam int          TRN_S1_BIT        = 6;
   localparam int          TRN_SB1_BIT       = 7;
   localparam int          MSTAT_HOOK_BIT    = 2;
   localparam logic [2:0]  TX_SILENCE        = 3'h0;
   localparam logic [2:0]  TX_USB1_1200      = 3'h1;
   localparam logic [2:0]  TX_S1             = 3'h2;
   localparam logic [2:0]  TX_SB1_1200       = 3'h3;
   localparam logic [2:0]  TX_SB1_2400       = 3'h4;
   localparam logic [2:0]  TX_DATA_1200      = 3'h5;
   localparam logic [2:0]  TX_DATA_2400      = 3'h6;
   localparam logic [2:0]  TX_TONE_2225      = 3'h7;
   localparam logic [3:0]  DIGIT_STAR        = 4'hA;
   localparam logic [3:0]  DIGIT_HASH        = 4'hB;
   localparam logic [15:0] LEVEL_SUM_MAX     = 16'h7800;
   localparam logic [15:0] PULSE_MAKE_NA     = 16'h024A;
   localparam logic [15:0] PULSE_BREAK_NA    = 16'h0176;
   localparam logic [16:0] PULSE_PAUSE_NA    = 17'h01C20;
   localparam logic [3:0]  DTMF_LOW_ROW_RST  = 4'h0;
endpackage

// File: logic/dial_tick.sv
// Purpose: interval timebase for dial sequencing
// Assumes: single clock, synchronous active-low reset
// Notes:   one-cycle pulse every TICKS cycles
`timescale 1ns/1ns
`default_nettype none
module dial_tick #(
   parameter int TICKS = 3125
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      tick
);
   logic [15:0] cnt_r;

   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b0;
      end else if (cnt_r == 16'(TICKS - 1)) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: logic/call_setup.sv
// Purpose: dial sequencer and manual handshake signal path of a data pump
// Assumes: host drives control bits as plain ports, synchronous to MCLK
// Notes:   tone and modem signal synthesis lie outside; this block selects them
`timescale 1ns/1ns
`default_nettype none
module call_setup
   import dial_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   input  wire logic [2:0]  MODE,
   input  wire logic        TX_REQUEST_BIT,
   input  wire logic        TIMED_DIAL_SELECT,
   input  wire logic        TONE_DIAL_SELECT,
   input  wire logic [3:0]  DIGIT,
   input  wire logic [15:0] FIRST_INTERVAL_COUNT,
   input  wire logic [15:0] SECOND_INTERVAL_COUNT,
   input  wire logic [16:0] INTERDIGIT_PAUSE_COUNT,
   input  wire logic [15:0] CONFIG_WORD,
   input  wire logic [2:0]  TX_SIGNAL_SELECT,
   input  wire logic        SIXTEEN_POINT_DECISION,
   input  wire logic        RX_USB1,
   input  wire logic        RX_S1,
   input  wire logic        RX_SB1,
   input  wire logic        RX_READY,
   input  wire logic        RX_DATA_IN,
   output logic             PUMP_BUSY_FLAG,
   output logic             HOOK_CONTROL_OUTPUT,
   output logic             LINE_SEIZED_FLAG,
   output logic             TONE_ON,
   output logic [3:0]       TONE_DIGIT,
   output logic             TONE_ROW_OK,
   output logic [2:0]       TX_SIGNAL,
   output logic [7:0]       TRAINING_STATUS,
   output logic             FORCE_SIXTEEN,
   output logic             RX_DATA_OUT
);
   import dial_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_FIRST, ST_SECOND, ST_PAUSE, ST_DONE} dial_state_type;

   dial_state_type dial_r;
   dial_state_type dial_nxt;
   logic [16:0]    cnt_r;
   logic [2:0]     rx_s1_r;
   logic [2:0]     rx_s2_r;
   logic [1:0]     rdy_sync_r;
   logic [1:0]     rxd_sync_r;
   logic           req_prev_r;
   logic           hold_mark_r;
   logic           tick;
   logic           dial_mode;
   logic           timed;
   logic           req_rise;
   logic           count_done;
   logic [15:0]    cfg_prev_r;

   function automatic logic valid_digit(input logic [3:0] d);
      // Every code maps to a key: 0-9, star, hash, A-D
      valid_digit = (d <= DIGIT_HASH) || (d > DIGIT_HASH);
   endfunction

   dial_tick #(.TICKS(TICK_CYC)) u_tick (
      .clk   (MCLK),
      .rst_n (RSTN),
      .run   (dial_r != ST_IDLE && dial_r != ST_DONE),
      .tick  (tick)
   );

   assign dial_mode  = (MODE == MODE_DIAL);
   assign timed      = TIMED_DIAL_SELECT || !TONE_DIAL_SELECT;
   assign req_rise   = TX_REQUEST_BIT && !req_prev_r;
   assign count_done = tick && (cnt_r <= 17'h00001);

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         req_prev_r <= 1'b0;
      end else begin
         req_prev_r <= TX_REQUEST_BIT;
      end
   end

   // Timed tone and pulse share one make/break sequencer; only pulse runs the pause
   always_comb begin
      dial_nxt = dial_r;
      unique case (dial_r)
         ST_IDLE: begin
            if (dial_mode && timed && req_rise) begin
               dial_nxt = ST_FIRST;
            end
         end
         ST_FIRST: begin
            if (!dial_mode) begin
               dial_nxt = ST_IDLE;
            end else if (count_done) begin
               dial_nxt = ST_SECOND;
            end
         end
         ST_SECOND: begin
            if (!dial_mode) begin
               dial_nxt = ST_IDLE;
            end else if (count_done) begin
               dial_nxt = TONE_DIAL_SELECT ? ST_DONE : ST_PAUSE;
            end
         end
         ST_PAUSE: begin
            if (!dial_mode || count_done) begin
               dial_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            if (!TX_REQUEST_BIT || !dial_mode) begin
               dial_nxt = ST_IDLE; // wait for host to drop request
            end
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         dial_r <= ST_IDLE;
         cnt_r  <= 17'h00000;
      end else begin
         dial_r <= dial_nxt;
         if (dial_r != dial_nxt) begin
            unique case (dial_nxt)
               ST_FIRST:  cnt_r <= {1'b0, FIRST_INTERVAL_COUNT};
               ST_SECOND: cnt_r <= {1'b0, SECOND_INTERVAL_COUNT};
               ST_PAUSE:  cnt_r <= INTERDIGIT_PAUSE_COUNT;
               default:   cnt_r <= 17'h00000;
            endcase
         end else if (tick && cnt_r != 17'h00000) begin
            cnt_r <= cnt_r - 17'h00001;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         PUMP_BUSY_FLAG <= 1'b0;
      end else begin
         PUMP_BUSY_FLAG <= (dial_nxt == ST_FIRST) || (dial_nxt == ST_SECOND)
                           || (dial_nxt == ST_PAUSE);
      end
   end

   // Tone pair: continuous follows request, timed follows make phase
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         TONE_ON     <= 1'b0;
         TONE_DIGIT  <= 4'h0;
         TONE_ROW_OK <= 1'b0;
      end else begin
         TONE_DIGIT  <= DIGIT[DIGIT_LSB +: DIGIT_W];
         TONE_ROW_OK <= valid_digit(DIGIT);
         if (!dial_mode || !TONE_DIAL_SELECT) begin
            TONE_ON <= 1'b0;
         end else if (!TIMED_DIAL_SELECT) begin
            TONE_ON <= TX_REQUEST_BIT;
         end else begin
            TONE_ON <= (dial_nxt == ST_FIRST);
         end
      end
   end

   // Pulse: break phase opens the loop; hook held seized otherwise, released while in reset
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         HOOK_CONTROL_OUTPUT <= 1'b0;
         LINE_SEIZED_FLAG    <= 1'b0;
      end else begin
         HOOK_CONTROL_OUTPUT <= !(dial_mode && !TONE_DIAL_SELECT && dial_nxt == ST_SECOND);
         LINE_SEIZED_FLAG    <= !(dial_mode && !TONE_DIAL_SELECT && dial_nxt == ST_SECOND);
      end
   end

   // Detect flags come from the demodulator clock region, so synchronise
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         rx_s1_r    <= 3'h0;
         rx_s2_r    <= 3'h0;
         rdy_sync_r <= 2'h0;
         rxd_sync_r <= 2'h3;
      end else begin
         rx_s1_r    <= {RX_SB1, RX_S1, RX_USB1};
         rx_s2_r    <= rx_s1_r;
         rdy_sync_r <= {rdy_sync_r[0], RX_READY};
         rxd_sync_r <= {rxd_sync_r[0], RX_DATA_IN};
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         TRAINING_STATUS <= 8'h00;
         FORCE_SIXTEEN   <= 1'b0;
      end else begin
         TRAINING_STATUS                  <= 8'h00;
         TRAINING_STATUS[2:0]             <= TX_SIGNAL_SELECT;
         TRAINING_STATUS[TRN_FORCE16_BIT] <= SIXTEEN_POINT_DECISION;
         TRAINING_STATUS[TRN_USB1_BIT]    <= rx_s2_r[0];
         TRAINING_STATUS[TRN_S1_BIT]      <= rx_s2_r[1];
         TRAINING_STATUS[TRN_SB1_BIT]     <= rx_s2_r[2];
         FORCE_SIXTEEN                    <= SIXTEEN_POINT_DECISION;
      end
   end

   // Manual mode passes only the host's selection; otherwise silence here
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         TX_SIGNAL <= TX_SILENCE;
      end else if (CONFIG_WORD[CFG_MANUAL_BIT]) begin
         TX_SIGNAL <= TX_SIGNAL_SELECT;
      end else begin
         TX_SIGNAL <= TX_SILENCE;
      end
   end

   // Any config value change rearms the mark hold until receiver reports ready
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         cfg_prev_r  <= 16'h0000;
         hold_mark_r <= 1'b1;
         RX_DATA_OUT <= 1'b1;
      end else begin
         cfg_prev_r <= CONFIG_WORD;
         if (CONFIG_WORD != cfg_prev_r) begin
            hold_mark_r <= 1'b1;
         end else if (rdy_sync_r[1]) begin
            hold_mark_r <= 1'b0;
         end
         // Mark from the change edge itself, not one cycle late
         RX_DATA_OUT <= (hold_mark_r || CONFIG_WORD != cfg_prev_r) ? 1'b1 : rxd_sync_r[1];
      end
   end
endmodule
`default_nettype wire

// File: verif/call_setup_chk.sv
// Purpose: port checker for call_setup
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every call_setup instance
`timescale 1ns/1ns
`default_nettype none
module call_setup_chk (
   input wire logic        MCLK,
   input wire logic        RSTN,
   input wire logic [2:0]  MODE,
   input wire logic        TX_REQUEST_BIT,
   input wire logic        TIMED_DIAL_SELECT,
   input wire logic        TONE_DIAL_SELECT,
   input wire logic [15:0] CONFIG_WORD,
   input wire logic [2:0]  TX_SIGNAL_SELECT,
   input wire logic        SIXTEEN_POINT_DECISION,
   input wire logic        RX_USB1,
   input wire logic        RX_S1,
   input wire logic        RX_SB1,
   input wire logic        PUMP_BUSY_FLAG,
   input wire logic        HOOK_CONTROL_OUTPUT,
   input wire logic        LINE_SEIZED_FLAG,
   input wire logic        TONE_ON,
   input wire logic [2:0]  TX_SIGNAL,
   input wire logic [7:0]  TRAINING_STATUS,
   input wire logic        FORCE_SIXTEEN,
   input wire logic        RX_DATA_OUT
);
   import dial_pkg::*;
   int         bcnt_r;
   wire logic [2:0] det_w = {RX_SB1, RX_S1, RX_USB1};
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);
   always_ff @(posedge MCLK) begin
      if (!RSTN || !PUMP_BUSY_FLAG)
         bcnt_r <= 0;
      else
         bcnt_r <= bcnt_r + 1;
   end
   hook_mirror_a: assert property (LINE_SEIZED_FLAG == HOOK_CONTROL_OUTPUT)
      else $error("hook status mirror differs");
   manual_tx_a: assert property (RSTN && CONFIG_WORD[CFG_MANUAL_BIT] |=> TX_SIGNAL == $past(TX_SIGNAL_SELECT))
      else $error("transmit signal not the host choice");
   auto_quiet_a: assert property (RSTN && !CONFIG_WORD[CFG_MANUAL_BIT] |=> TX_SIGNAL == TX_SILENCE)
      else $error("handshake signal sent unasked");
   force_dec_a: assert property (RSTN |=> FORCE_SIXTEEN == $past(SIXTEEN_POINT_DECISION))
      else $error("sixteen-way decision not forced");
   detect_lat_a: assert property (RSTN [*4] |-> TRAINING_STATUS[TRN_SB1_BIT:TRN_USB1_BIT] == $past(det_w, 3))
      else $error("detect flags wrong");
   busy_start_a: assert property (MODE == MODE_DIAL && (TIMED_DIAL_SELECT || !TONE_DIAL_SELECT)
      && $rose(TX_REQUEST_BIT) && !PUMP_BUSY_FLAG && $past(RSTN) |=> PUMP_BUSY_FLAG)
      else $error("busy not raised");
   busy_hold_a: assert property ($fell(PUMP_BUSY_FLAG) && MODE == MODE_DIAL |-> bcnt_r >= TICK_CYC)
      else $error("busy too short");
   tone_follow_a: assert property (RSTN && MODE == MODE_DIAL && TONE_DIAL_SELECT && !TIMED_DIAL_SELECT
      |=> TONE_ON == $past(TX_REQUEST_BIT))
      else $error("continuous tone not following request");
   rx_mark_a: assert property (RSTN && $changed(CONFIG_WORD) |=> RX_DATA_OUT)
      else $error("receive data not held at mark");
   busy_c: cover property ($rose(PUMP_BUSY_FLAG));
   pulse_c: cover property ($fell(HOOK_CONTROL_OUTPUT));
   rx_c: cover property ($fell(RX_DATA_OUT));
endmodule
bind call_setup call_setup_chk chk (.*);
`default_nettype wire

// File: verif/remote_modem.sv
// Purpose: far modem as seen through the receive pins
// Assumes: sig is the handshake code the far end sends
// Notes:   unready data line toggles so a stale bit never looks valid
`timescale 1ns/1ns
`default_nettype none
module remote_modem (
   input  wire logic       clk,
   input  wire logic [2:0] sig,
   input  wire logic       rdy,
   input  wire logic       dat,
   output logic            usb1,
   output logic            s1,
   output logic            sb1,
   output logic            ready,
   output logic            rxd
);
   logic tgl_r = 1'b0;
   always_ff @(posedge clk)
      tgl_r <= !tgl_r;
   assign usb1 = (sig == 3'h1);
   assign s1 = (sig == 3'h2);
   assign sb1 = (sig == 3'h3) || (sig == 3'h4);
   assign ready = rdy;
   assign rxd = rdy ? dat : tgl_r;
endmodule
`default_nettype wire

// File: verif/tb_call_setup.sv
// Purpose: self-checking bench for call_setup
// Assumes: 25 MHz MCLK, one-tick interval counts
// Notes:   host sequence here, far modem in remote_modem
`timescale 1ns/1ns
`default_nettype none
module tb_call_setup;
   import dial_pkg::*;
   logic        mclk = 1'b0, rstn = 1'b0, req = 1'b0, timed = 1'b0, tone = 1'b1;
   logic        sixteen = 1'b0, rdy = 1'b0, dat = 1'b0;
   logic [2:0]  mode = 3'h0, sel = 3'h0, rsig = 3'h0, txs;
   logic [3:0]  digit = 4'h0, tdig;
   logic [15:0] cnt1 = 16'h0001, cnt2 = 16'h0001, cfg = 16'h0000;
   logic [16:0] cnt3 = 17'h00001;
   logic [7:0]  trn;
   logic        busy, hook, seized, tone_on, row_ok, f16, rxo, usb1, s1, sb1, ready, rxd;
   int          seed, i, mismatches = 0, n_tests = 0;
   call_setup dut (.MCLK(mclk), .RSTN(rstn), .MODE(mode), .TX_REQUEST_BIT(req),
      .TIMED_DIAL_SELECT(timed), .TONE_DIAL_SELECT(tone), .DIGIT(digit),
      .FIRST_INTERVAL_COUNT(cnt1), .SECOND_INTERVAL_COUNT(cnt2), .INTERDIGIT_PAUSE_COUNT(cnt3),
      .CONFIG_WORD(cfg), .TX_SIGNAL_SELECT(sel), .SIXTEEN_POINT_DECISION(sixteen),
      .RX_USB1(usb1), .RX_S1(s1), .RX_SB1(sb1), .RX_READY(ready), .RX_DATA_IN(rxd),
      .PUMP_BUSY_FLAG(busy), .HOOK_CONTROL_OUTPUT(hook), .LINE_SEIZED_FLAG(seized),
      .TONE_ON(tone_on), .TONE_DIGIT(tdig), .TONE_ROW_OK(row_ok), .TX_SIGNAL(txs),
      .TRAINING_STATUS(trn), .FORCE_SIXTEEN(f16), .RX_DATA_OUT(rxo));
   remote_modem far (.clk(mclk), .sig(rsig), .rdy(rdy), .dat(dat), .usb1(usb1), .s1(s1),
      .sb1(sb1), .ready(ready), .rxd(rxd));
   initial begin
      forever #20 mclk = ~mclk;
   end
   function automatic logic [2:0] det_exp(input logic [2:0] s);
      return {s == TX_SB1_1200 || s == TX_SB1_2400, s == TX_S1, s == TX_USB1_1200};
   endfunction
   function automatic logic [2:0] tx_exp(input logic [15:0] c, input logic [2:0] s);
      return c[CFG_MANUAL_BIT] ? s : TX_SILENCE;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Reads land before this edge's updates, so values seen are settled
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One host handshake step: pick the signal, far end answers, then check
   task automatic hs_step(input logic [2:0] s, input logic [2:0] far, input logic f, input int n);
      sel <= s;
      rsig <= far;
      sixteen <= f;
      cyc(n);
      chk("tx signal", txs, tx_exp(cfg, s));
      chk("detect", trn[7:5], det_exp(far));
      chk("force16", f16, f);
      chk("train low", trn[3:0], {f, s});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #1_600_000;
      mismatches++;
      summarize();
   end
   initial begin
      seed = 40;
      cyc(16);
      rstn <= 1'b1;
      cyc(3);
      chk("busy rst", busy, 8'h00);
      chk("hook rst", hook, 8'h01);
      // Tone levels sit outside; host keeps their sum under LEVEL_SUM_MAX
      mode <= MODE_DIAL;
      for (i = 0; i < 16; i++) begin
         digit <= 4'(i);
         req <= 1'b1;
         cyc(3);
         chk("tone on", tone_on, 8'h01);
         chk("tone digit", tdig, 8'(i));
         chk("row ok", row_ok, 8'h01);
         req <= 1'b0;
         cyc(3);
         chk("tone off", tone_on, 8'h00);
      end
      timed <= 1'b1;
      digit <= 4'($random(seed));
      cyc(2);
      req <= 1'b1;
      cyc(3);
      chk("timed busy", busy, 8'h01);
      chk("timed tone", tone_on, 8'h01);
      for (i = 0; i < 4 * TICK_CYC && busy !== 1'b0; i++)
         cyc(1);
      chk("busy span", 8'(i >= TICK_CYC), 8'h01);
      chk("tone quiet", tone_on, 8'h00);
      // Request still high: no second digit may start
      cyc(5);
      chk("no rearm", busy, 8'h00);
      req <= 1'b0;
      tone <= 1'b0;
      timed <= 1'b0;
      cyc(2);
      req <= 1'b1;
      for (i = 0; i < 4 * TICK_CYC && hook !== 1'b0; i++)
         cyc(1);
      chk("hook break", hook, 8'h00);
      chk("seized break", seized, 8'h00);
      chk("pulse busy", busy, 8'h01);
      chk("pulse silent", tone_on, 8'h00);
      for (i = 0; i < 4 * TICK_CYC && busy !== 1'b0; i++)
         cyc(1);
      chk("hook make", hook, 8'h01);
      req <= 1'b0;
      cyc(2);
      req <= 1'b1;
      cyc(10);
      mode <= MODE_STANDBY;
      cyc(3);
      chk("abort", busy, 8'h00);
      req <= 1'b0;
      cfg <= 16'h4409;
      for (i = 0; i < 40; i++)
         hs_step(3'(i), 3'($random(seed)), 1'($random(seed)), 4);
      // Originate: steady ones, then S1 path up to 2400 data
      hs_step(TX_SILENCE, TX_USB1_1200, 1'b0, 4);
      for (i = 0; i < 8; i++) begin
         cyc(1);
         chk("ones steady", trn[TRN_USB1_BIT], 8'h01);
      end
      hs_step(TX_S1, TX_USB1_1200, 1'b0, 4);
      hs_step(TX_SB1_1200, TX_S1, 1'b0, 4);
      hs_step(TX_SB1_1200, TX_SILENCE, 1'b1, 4);
      hs_step(TX_SB1_2400, TX_SB1_2400, 1'b1, 4);
      hs_step(TX_DATA_2400, TX_DATA_2400, 1'b1, 4);
      // Fallback when scrambled ones come instead of S1
      hs_step(TX_SB1_1200, TX_SB1_1200, 1'b0, 4);
      hs_step(TX_DATA_1200, TX_DATA_1200, 1'b0, 4);
      cfg <= 16'h0008;
      sel <= TX_USB1_1200;
      cyc(4);
      chk("auto quiet", txs, TX_SILENCE);
      chk("rx held", rxo, 8'h01);
      hs_step(TX_S1, TX_S1, 1'b0, 4);
      hs_step(TX_SB1_1200, TX_SILENCE, 1'b1, 4);
      hs_step(TX_DATA_2400, TX_DATA_2400, 1'b1, 4);
      hs_step(TX_SB1_1200, TX_SB1_1200, 1'b0, 4);
      hs_step(TX_DATA_1200, TX_DATA_1200, 1'b0, 4);
      chk("rx still held", rxo, 8'h01);
      rdy <= 1'b1;
      cyc(6);
      chk("rx pass", rxo, 8'h00);
      dat <= 1'b1;
      cyc(6);
      chk("rx one", rxo, 8'h01);
      dat <= 1'b0;
      cfg <= 16'h0009;
      cyc(2);
      chk("rx rearm", rxo, 8'h01);
      cyc(4);
      chk("rx zero", rxo, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
